// File: psl_pkg.sv
// psl_pkg: constants and types for the power-on strap latch block
// assumes: one clock (mclk), asynchronous active-high reset
package psl_pkg;
  localparam int unsigned PSL_CORES = 8;
  localparam int unsigned PSL_SOCK_W = 2;
  // pin groups that the tri-state covers
  localparam int unsigned PSL_GRP_LINK = 0;
  localparam int unsigned PSL_GRP_SERX = 1;
  localparam int unsigned PSL_GRP_CHIP = 2;
  localparam int unsigned PSL_GRP_SMB = 3;
  localparam int unsigned PSL_GRP_SIDE = 4;
  localparam int unsigned PSL_GRP_VREG = 5;
  localparam int unsigned PSL_GRPS = 6;
  // default levels of undriven straps
  localparam logic PSL_PULL_SELFTEST = 1'b1;
  localparam logic PSL_PULL_DEBUG_N = 1'b1;
  localparam logic PSL_PULL_HALT_N = 1'b1;
  localparam logic PSL_PULL_TRUSTED = 1'b1;
  localparam logic PSL_PULL_LOW = 1'b0;
  // reset values of the latched configuration
  localparam logic [PSL_SOCK_W-1:0] PSL_SOCK_RST = 2'h0;
  localparam logic [PSL_CORES-1:0] PSL_CORE_DIS_RST = 8'h00;

  typedef enum logic [2:0]
  {
    PSL_IDLE = 3'b001,
    PSL_RUN = 3'b010,
    PSL_TRI = 3'b100
  } psl_state_t;
endpackage

// File: psl_sync_if.sv
// psl_sync_if: raw pin levels into the synchroniser, clean levels out
// assumes: both ends on mclk
interface psl_sync_if;
  logic [13:0] raw;
  logic [13:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface

// File: psl_sync.sv
// psl_sync: two-flip-flop synchroniser for all strap and latch pins
// assumes: pins are asynchronous to mclk
module psl_sync
  import psl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pin levels
  psl_sync_if.snk sif
);
  typedef struct packed
  {
    logic [13:0] s1;
    logic [13:0] s2;
  } psl_sync_st_t;

  psl_sync_st_t st_r;
  psl_sync_st_t st_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = sif.raw;
    st_nxt.s2 = st_r.s1;
  end

  // reset to zero, straps settle long before they are latched
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sif.clean = st_r.s2;
endmodule

// File: psl_latch.sv
// psl_latch: latches power-on straps and drives socket tri-state
// assumes: straps may float (enable=0 means undriven); mclk 20 MHz
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - capture straps on reset release or on power-good rising edge.
// - captured values hold until the next edge of their latching signal.
// - thermal alert pin is latched on reset release as tri-state strap.
// - self-test request sampled on reset release; starts built-in self test.
// - boot, security, socket and debug straps sampled after power-good rises.
// - alert low at reset release puts all socket outputs in high impedance.
// - tri-state covers link, serial, chipset, smbus, sideband, vreg groups.
// - a register lets firmware disable individual cores.
// - boot-mode straps select service, halt, trusted, agent, safe modes.
// - debug strap active permits debug access from cold boot.
// - undriven straps default to their internal pull levels.
module psl_latch
  import psl_pkg::*;
(
  // clock and system reset
  input wire logic mclk,
  input wire logic sys_rst,
  // latching signals from the board (pins)
  input wire logic plat_reset_n,
  input wire logic power_ok_in,
  // straps: level and whether board drives it (alert pin: level only, no drive flag)
  input wire logic thermal_alert_pin_n,
  input wire logic selftest_request_strap,
  input wire logic selftest_request_drv,
  input wire logic service_proc_boot_strap,
  input wire logic service_proc_boot_drv,
  input wire logic powerup_halt_strap_n,
  input wire logic powerup_halt_drv,
  input wire logic trusted_platform_strap,
  input wire logic trusted_platform_drv,
  input wire logic firmware_agent_strap,
  input wire logic firmware_agent_drv,
  input wire logic trusted_agent_strap,
  input wire logic trusted_agent_drv,
  input wire logic safe_boot_strap,
  input wire logic safe_boot_drv,
  input wire logic [1:0] socket_number_strap,
  input wire logic socket_number_drv,
  input wire logic debug_enable_strap_n,
  input wire logic debug_enable_drv,
  // core disable register write port (same clock domain)
  input wire logic core_dis_we,
  input wire logic [PSL_CORES-1:0] core_dis_wdata,
  // self-test completion from the core logic (same clock domain)
  input wire logic selftest_done,
  // latched configuration
  output logic selftest_run,
  output logic service_proc_boot,
  output logic powerup_halt,
  output logic trusted_platform_en,
  output logic firmware_agent,
  output logic trusted_agent,
  output logic safe_boot,
  output logic [PSL_SOCK_W-1:0] socket_number,
  output logic cold_debug_en,
  output logic [PSL_CORES-1:0] core_disable,
  // per-group output enable kill, high while socket is tri-stated
  output logic [PSL_GRPS-1:0] group_tristate,
  output logic fault_tolerant_boot
);
  //////////////////////////////////////////////////////////////////////////////
  // synchronise every pin, defaulting undriven straps
  psl_sync_if sif ();
  logic [13:0] c;

  // pull levels applied before sync so a floating pin reads its default
  assign sif.raw = {
    plat_reset_n,
    power_ok_in,
    thermal_alert_pin_n,
    selftest_request_drv ? selftest_request_strap : PSL_PULL_SELFTEST,
    service_proc_boot_drv ? service_proc_boot_strap : PSL_PULL_LOW,
    powerup_halt_drv ? powerup_halt_strap_n : PSL_PULL_HALT_N,
    trusted_platform_drv ? trusted_platform_strap : PSL_PULL_TRUSTED,
    firmware_agent_drv ? firmware_agent_strap : PSL_PULL_LOW,
    trusted_agent_drv ? trusted_agent_strap : PSL_PULL_LOW,
    safe_boot_drv ? safe_boot_strap : PSL_PULL_LOW,
    socket_number_drv ? socket_number_strap : {2{PSL_PULL_LOW}},
    debug_enable_drv ? debug_enable_strap_n : PSL_PULL_DEBUG_N,
    // spare bit 0 fills the 14-bit word so fields sit at c[13:1]
    1'b0
  };

  psl_sync u_sync
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  assign c = sif.clean;

  //////////////////////////////////////////////////////////////////////////////
  // block state
  typedef struct packed
  {
    logic rst_n_d;
    logic pok_d;
    logic primed;
    logic [1:0] warm;
    psl_state_t st;
    logic tri_en;
    logic selftest;
    logic svc;
    logic halt;
    logic tplat;
    logic fwa;
    logic tag;
    logic safe;
    logic [PSL_SOCK_W-1:0] sock;
    logic dbg;
    logic [PSL_CORES-1:0] cdis;
  } psl_st_t;

  psl_st_t s_r;
  psl_st_t s_nxt;
  logic rst_rel;
  logic pok_rise;

  // edges are taken only once the sync chain and the delay flops hold
  // real pin samples, so their reset zeros cannot fake an edge when a
  // pin is already high as sys_rst is released
  assign rst_rel = s_r.primed && c[13] && !s_r.rst_n_d;
  assign pok_rise = s_r.primed && c[12] && !s_r.pok_d;

  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rst_n_d = c[13];
    s_nxt.pok_d = c[12];
    // warm-up: two sync edges plus one delay edge before history is real
    s_nxt.warm = (s_r.warm == 2'h3) ? s_r.warm : 2'(s_r.warm + 2'h1);
    s_nxt.primed = s_r.primed || (s_r.warm == 2'h2);
    // reset-latched group: tri-state strap and self-test request
    if (rst_rel)
    begin
      s_nxt.tri_en = !c[11];
      s_nxt.selftest = c[10];
    end
    // power-good-latched group
    if (pok_rise)
    begin
      s_nxt.svc = c[9];
      s_nxt.halt = !c[8];
      s_nxt.tplat = c[7];
      s_nxt.fwa = c[6];
      s_nxt.tag = c[5];
      s_nxt.safe = c[4];
      s_nxt.sock = c[3:2];
      s_nxt.dbg = !c[1];
    end
    // self-test sequencer; tri-stated socket runs nothing
    case (s_r.st)
      PSL_IDLE:
      begin
        if (rst_rel && c[10] && c[11])
          s_nxt.st = PSL_RUN;
        else if (rst_rel && !c[11])
          s_nxt.st = PSL_TRI;
      end
      PSL_RUN:
      begin
        // a new release re-decides from the freshly latched straps
        if (rst_rel && !c[11])
          s_nxt.st = PSL_TRI;
        else if (rst_rel)
          s_nxt.st = c[10] ? PSL_RUN : PSL_IDLE;
        else if (selftest_done)
          s_nxt.st = PSL_IDLE;
      end
      PSL_TRI:
      begin
        // leave only on a release with alert inactive
        if (rst_rel && c[11])
          s_nxt.st = c[10] ? PSL_RUN : PSL_IDLE;
      end
      default:
        s_nxt.st = PSL_IDLE;
    endcase
    // core disable register, firmware-written
    if (core_dis_we)
      s_nxt.cdis = core_dis_wdata;
  end

  // state register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.st <= PSL_IDLE;
      s_r.halt <= !PSL_PULL_HALT_N;
      s_r.tplat <= PSL_PULL_TRUSTED;
      s_r.selftest <= PSL_PULL_SELFTEST;
      s_r.sock <= PSL_SOCK_RST;
      s_r.cdis <= PSL_CORE_DIS_RST;
    end
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, except selftest_run, which is decoded from the state register
  assign selftest_run = s_r.st == PSL_RUN;
  assign service_proc_boot = s_r.svc;
  assign powerup_halt = s_r.halt;
  assign trusted_platform_en = s_r.tplat;
  assign firmware_agent = s_r.fwa;
  assign trusted_agent = s_r.tag;
  assign safe_boot = s_r.safe;
  assign socket_number = s_r.sock;
  assign cold_debug_en = s_r.dbg;
  assign core_disable = s_r.cdis;
  assign fault_tolerant_boot = s_r.tri_en;
  assign group_tristate = {PSL_GRPS{s_r.tri_en}};

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_tri_on_release: assert property (@(posedge mclk) disable iff (sys_rst)
    rst_rel |=> fault_tolerant_boot == !$past(c[11]))
    else $error("tri-state not latched from alert at reset release");
  a_tri_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    !rst_rel |=> $stable(fault_tolerant_boot))
    else $error("tri-state changed without reset release");
  a_grp_cover: assert property (@(posedge mclk) disable iff (sys_rst)
    group_tristate == {PSL_GRPS{fault_tolerant_boot}})
    else $error("pin group tri-state mismatch");
  a_sock_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    pok_rise |=> socket_number == $past(c[3:2]))
    else $error("socket number not latched on power-good");
  a_pok_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !pok_rise |=> $stable(socket_number) && $stable(safe_boot)
      && $stable(cold_debug_en) && $stable(powerup_halt))
    else $error("power-good group changed without edge");
  a_boot_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    pok_rise |=> service_proc_boot == $past(c[9])
      && powerup_halt == !$past(c[8]) && trusted_agent == $past(c[5]))
    else $error("boot mode straps latched wrong");
  a_dbg_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    pok_rise |=> cold_debug_en == !$past(c[1]))
    else $error("debug strap latched wrong");
  a_selftest_go: assert property (@(posedge mclk) disable iff (sys_rst)
    rst_rel && c[10] && c[11] |=> selftest_run)
    else $error("self test did not start");
  a_core_dis: assert property (@(posedge mclk) disable iff (sys_rst)
    core_dis_we |=> core_disable == $past(core_dis_wdata))
    else $error("core disable write lost");
  a_rst_edge: assert property (@(posedge mclk) disable iff (sys_rst)
    s_r.primed && !c[13] ##1 c[13] |-> rst_rel)
    else $error("reset release edge missed");
endmodule

// File: psl_board.sv
// psl_board: behavioural board logic that drives reset, power-good, alert
// assumes: callers return 1 ns after a rising edge of mclk
module psl_board
(
  // clock
  input wire logic mclk,
  // latching and alert pins
  output logic plat_reset_n,
  output logic power_ok_in,
  output logic thermal_alert_pin_n
);
  timeunit 1ns;
  timeprecision 100ps;
  //////////////////////////////////////////////////////////////////////
  // pins start in reset with power not yet good
  initial
  begin
    plat_reset_n = 1'b0;
    power_ok_in = 1'b0;
    thermal_alert_pin_n = 1'b1;
  end
  // six cycles per level, so the 2-flop sync and the strap setup are met
  task automatic hold6();
    repeat (6) @(posedge mclk);
    #1;
  endtask
  // reset pulse; alert held across the release removes the socket
  task automatic reset_pulse(input logic alert_n);
    plat_reset_n = 1'b0;
    thermal_alert_pin_n = alert_n;
    hold6();
    plat_reset_n = 1'b1;
    hold6();
    // flip alert afterwards: a late sample would show up at once
    thermal_alert_pin_n = ~alert_n;
  endtask
  // power-good drop and rise
  task automatic pok_pulse();
    power_ok_in = 1'b0;
    hold6();
    power_ok_in = 1'b1;
    hold6();
  endtask
endmodule

// File: tb_top.sv
// tb_top: strap latch bench, integer model compared at every result
// assumes: psl_pkg, psl_sync_if, psl_sync, psl_latch, psl_board compiled
module tb_top
  import psl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic prst_n, pok, alert_n;
  logic [9:0] lvl = 10'h000;
  logic [8:0] drv = 9'h000;
  logic [9:0] pull = 10'h20d;
  logic [9:0] e;
  logic we = 1'b0;
  logic done = 1'b0;
  logic [7:0] wd = 8'h00;
  logic st, spb, hlt, tpe, fwa, tra, sfb, dbg, ftb;
  logic [1:0] sock;
  logic [7:0] cdis;
  logic [5:0] grp;
  logic [31:0] seed = 32'h49;
  int mismatches = 0;
  int n_compared = 0;
  int m_ftb, m_st, m_cfg, m_core;
  //////////////////////////////////////////////////////////////////////
  always #25 mclk = ~mclk;
  psl_board brd
  (
    .mclk(mclk),
    .plat_reset_n(prst_n),
    .power_ok_in(pok),
    .thermal_alert_pin_n(alert_n)
  );
  psl_latch dut
  (
    .mclk(mclk), .sys_rst(sys_rst), .plat_reset_n(prst_n),
    .power_ok_in(pok), .thermal_alert_pin_n(alert_n),
    .selftest_request_strap(lvl[0]), .selftest_request_drv(drv[0]),
    .service_proc_boot_strap(lvl[1]), .service_proc_boot_drv(drv[1]),
    .powerup_halt_strap_n(lvl[2]), .powerup_halt_drv(drv[2]),
    .trusted_platform_strap(lvl[3]), .trusted_platform_drv(drv[3]),
    .firmware_agent_strap(lvl[4]), .firmware_agent_drv(drv[4]),
    .trusted_agent_strap(lvl[5]), .trusted_agent_drv(drv[5]),
    .safe_boot_strap(lvl[6]), .safe_boot_drv(drv[6]),
    .socket_number_strap(lvl[8:7]), .socket_number_drv(drv[7]),
    .debug_enable_strap_n(lvl[9]), .debug_enable_drv(drv[8]),
    .core_dis_we(we), .core_dis_wdata(wd), .selftest_done(done),
    .selftest_run(st), .service_proc_boot(spb), .powerup_halt(hlt),
    .trusted_platform_en(tpe), .firmware_agent(fwa), .trusted_agent(tra),
    .safe_boot(sfb), .socket_number(sock), .cold_debug_en(dbg),
    .core_disable(cdis), .group_tristate(grp), .fault_tolerant_boot(ftb)
  );
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // strap levels as latched: undriven pins take their pull level
  function automatic logic [9:0] eff();
    logic [9:0] v;
    for (int i = 0; i < 10; i++)
      v[i] = drv[i < 7 ? i : (i < 9 ? 7 : 8)] ? lvl[i] : pull[i];
    return v;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk_all();
    chk("ftb", m_ftb, ftb);
    chk("grp", m_ftb ? 32'h3f : 32'h0, grp);
    chk("selftest_run", m_st, st);
    chk("sp_boot", m_cfg[1], spb);
    chk("halt", !m_cfg[2], hlt);
    chk("trusted_pl", m_cfg[3], tpe);
    chk("fw_agent", m_cfg[4], fwa);
    chk("trusted_ag", m_cfg[5], tra);
    chk("safe_boot", m_cfg[6], sfb);
    chk("socket", m_cfg[8:7], sock);
    chk("cold_debug", !m_cfg[9], dbg);
    chk("core_dis", m_core, cdis);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence; alert asserted on every third release
  initial
  begin
    tick(12);
    sys_rst = 1'b0;
    m_cfg = 10'h20c;
    m_ftb = 0;
    m_st = 0;
    m_core = 0;
    tick(2);
    chk_all();
    for (int k = 0; k < 8; k++)
    begin
      {drv, lvl} = 19'(rnd());
      brd.reset_pulse(k % 3 != 1);
      e = eff();
      m_ftb = (k % 3 == 1);
      m_st = e[0] & !m_ftb;
      chk_all();
      {drv, lvl} = 19'(rnd());
      tick(4);
      chk_all();
      done = 1'b1;
      tick(1);
      done = 1'b0;
      m_st = 0;
      tick(1);
      chk("selftest_end", m_st, st);
      brd.pok_pulse();
      m_cfg = eff();
      chk_all();
      wd = 8'(rnd());
      we = 1'b1;
      m_core = wd;
      tick(1);
      // data moves with no write: must not land
      we = 1'b0;
      wd = ~wd;
      tick(2);
      chk("core_dis_wr", m_core, cdis);
    end
    // mid-run reset with reset and power-good pins already high:
    // no release or rise may be seen, self-test strap floats high
    drv = 9'h000;
    tick(2);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    m_cfg = 10'h20c;
    m_ftb = 0;
    m_st = 0;
    m_core = 0;
    tick(6);
    chk_all();
    end_sim();
  end
  // watchdog: run needs about 300 cycles, allow 2000
  initial
  begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
